//--- rtl/usspi_pkg.sv
// Shared constants, register map and carrier types of the USART SPI-mode channel
package usspi_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] A_RCTL = 8'h00;
    localparam logic [7:0] A_CTL = 8'h04;
    localparam logic [7:0] A_DIVLO = 8'h08;
    localparam logic [7:0] A_DIVHI = 8'h0C;
    localparam logic [7:0] A_MOD = 8'h10;
    localparam logic [7:0] A_RXBUF = 8'h14;
    localparam logic [7:0] A_TXBUF = 8'h18;
    localparam logic [7:0] A_ME2 = 8'h1C;
    localparam logic [7:0] A_IE1 = 8'h20;
    localparam logic [7:0] A_IE2 = 8'h24;
    localparam logic [7:0] A_FLAGS = 8'h28;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int B_CONFLICT = 7;
    localparam int B_OVERRUN = 5;
    localparam int B_SPI_EN = 4;
    localparam int B_TXIE0 = 7;
    localparam int B_RXIE0 = 6;
    localparam int B_TXIE1 = 5;
    localparam int B_RXIE1 = 4;
    localparam int B_FLG_RX = 0;
    localparam int B_FLG_TX = 1;

    // ----------------------------------------------------------------
    // Reset values and fixed figures
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h02;
    localparam logic [15:0] DIV_MIN = 16'h0002;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_7 = 4'h7;
    localparam logic [23:0] RD_PAD = 24'h00_0000;

    // Engine states, one-hot
    typedef enum logic [1:0] {
        USSPI_IDLE = 2'b01,
        USSPI_SHIFT = 2'b10
    } usspi_state_t;

    // Control register layout
    typedef struct packed {
        logic [3:0] spare;
        logic seven_bit;
        logic pin_mode_select;
        logic clock_polarity_select;
        logic master;
    } usspi_ctl_t;

endpackage : usspi_pkg

//--- rtl/usspi_top.sv
// USART SPI-mode channel: transmit FIFO, APB register file and shift engine
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Transmit FIFO
// ----------------------------------------------------------------
module usspi_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } usspi_fifo_st_t;

    usspi_fifo_st_t s_ff;
    usspi_fifo_st_t nxt_s;
    logic push;
    logic pop;

    // Honest flags straight from the occupancy count
    assign in_ready = (s_ff.count != (AW+1)'(D));
    assign out_valid = (s_ff.count != '0);
    assign out_data = s_ff.mem[s_ff.rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers wrap explicitly so any depth works
    always_comb begin
        nxt_s = s_ff;
        if (push) begin
            nxt_s.mem[s_ff.wptr] = in_data;
            nxt_s.wptr = (s_ff.wptr == AW'(D-1)) ? '0 : s_ff.wptr + AW'(1);
        end
        if (pop) begin
            nxt_s.rptr = (s_ff.rptr == AW'(D-1)) ? '0 : s_ff.rptr + AW'(1);
        end
        nxt_s.count = s_ff.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule : usspi_fifo

// ----------------------------------------------------------------
// Channel top
// ----------------------------------------------------------------
module usspi_top #(
    parameter int CHANNEL = 1,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    input wire logic simo_i,
    output logic simo_o,
    output logic simo_oe,
    input wire logic somi_i,
    output logic somi_o,
    output logic somi_oe,
    input wire logic slave_select_pin_i,
    output logic tx_irq,
    output logic rx_irq
);
    typedef struct packed {
        logic [7:0] rctl;
        logic [7:0] ctl;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] modul;
        logic [7:0] rxbuf;
        logic [7:0] txlast;
        logic [7:0] me2;
        logic [7:0] ie1;
        logic [7:0] ie2;
        logic rx_flag;
        logic tx_flag;
        logic [2:0] sck_s;
        logic [2:0] simo_s;
        logic [2:0] somi_s;
        logic [2:0] ss_s;
        usspi_pkg::usspi_state_t st;
        logic [15:0] dcnt;
        logic [3:0] bcnt;
        logic [7:0] tx_sh;
        logic [7:0] rx_sh;
        logic sclk;
        logic dout;
        logic [31:0] prdata;
    } usspi_st_t;

    usspi_st_t s_ff;
    usspi_st_t nxt_s;
    usspi_pkg::usspi_ctl_t c;
    logic acc, fire, wr, rd, en, sel, din, lead, trail, done, pop;
    logic f_in_ready, f_out_valid;
    logic [7:0] f_out_data, rx_char;
    logic [15:0] divc, half;
    logic [3:0] nbits;

    // Address decode is used for the error answer and to gate accepted transfers
    function automatic logic mapped(input logic [7:0] a);
        case (a)
            usspi_pkg::A_RCTL, usspi_pkg::A_CTL, usspi_pkg::A_DIVLO,
            usspi_pkg::A_DIVHI, usspi_pkg::A_MOD, usspi_pkg::A_RXBUF,
            usspi_pkg::A_TXBUF, usspi_pkg::A_ME2, usspi_pkg::A_IE1,
            usspi_pkg::A_IE2, usspi_pkg::A_FLAGS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    function automatic logic [7:0] rd_byte(input logic [7:0] a, input usspi_st_t s);
        case (a)
            usspi_pkg::A_RCTL: rd_byte = s.rctl;
            usspi_pkg::A_CTL: rd_byte = s.ctl;
            usspi_pkg::A_DIVLO: rd_byte = s.div_lo;
            usspi_pkg::A_DIVHI: rd_byte = s.div_hi;
            usspi_pkg::A_MOD: rd_byte = s.modul;
            usspi_pkg::A_RXBUF: rd_byte = s.rxbuf;
            usspi_pkg::A_TXBUF: rd_byte = s.txlast;
            usspi_pkg::A_ME2: rd_byte = s.me2;
            usspi_pkg::A_IE1: rd_byte = s.ie1;
            usspi_pkg::A_IE2: rd_byte = s.ie2;
            usspi_pkg::A_FLAGS: begin
                rd_byte = usspi_pkg::RST_BYTE;
                rd_byte[usspi_pkg::B_FLG_RX] = s.rx_flag;
                rd_byte[usspi_pkg::B_FLG_TX] = s.tx_flag;
            end
            default: rd_byte = usspi_pkg::RST_BYTE;
        endcase
    endfunction : rd_byte

    // ----------------------------------------------------------------
    // APB handshake
    // ----------------------------------------------------------------
    // Only a transmit write into a full FIFO stalls; all else is zero-wait
    assign acc = psel && penable;
    assign pready = !(acc && pwrite && (paddr == usspi_pkg::A_TXBUF) && !f_in_ready);
    assign pslverr = acc && !mapped(paddr);
    assign fire = acc && pready && mapped(paddr);
    assign wr = fire && pwrite;
    assign rd = fire && !pwrite;
    assign prdata = s_ff.prdata;

    // ----------------------------------------------------------------
    // Shared decode of configuration and pins
    // ----------------------------------------------------------------
    assign c = usspi_pkg::usspi_ctl_t'(s_ff.ctl);
    assign en = s_ff.me2[usspi_pkg::B_SPI_EN];
    assign sel = c.pin_mode_select || !s_ff.ss_s[1];
    assign din = c.master ? s_ff.somi_s[1] : s_ff.simo_s[1];
    assign divc = ({s_ff.div_hi, s_ff.div_lo} < usspi_pkg::DIV_MIN) ?
        usspi_pkg::DIV_MIN : {s_ff.div_hi, s_ff.div_lo};
    assign half = divc >> 1;
    assign nbits = c.seven_bit ? usspi_pkg::BITS_7 : usspi_pkg::BITS_8;
    assign rx_char = {s_ff.rx_sh[6:0], din};

    // Transmit data waits here; a full FIFO holds off the APB write
    usspi_fifo #(
        .W(8),
        .D(FIFO_DEPTH)
    ) u_txfifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(wr && (paddr == usspi_pkg::A_TXBUF)),
        .in_ready(f_in_ready),
        .in_data(pwdata[7:0]),
        .out_valid(f_out_valid),
        .out_ready(pop),
        .out_data(f_out_data)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        lead = 1'b0;
        trail = 1'b0;
        done = 1'b0;
        pop = 1'b0;
        // Pin synchronisers; stage 2 vs 3 gives edges
        nxt_s.sck_s = {s_ff.sck_s[1:0], serial_clock_pin_i};
        nxt_s.simo_s = {s_ff.simo_s[1:0], simo_i};
        nxt_s.somi_s = {s_ff.somi_s[1:0], somi_i};
        nxt_s.ss_s = {s_ff.ss_s[1:0], slave_select_pin_i};
        if (psel && !penable) begin
            nxt_s.prdata = {usspi_pkg::RD_PAD, rd_byte(paddr, s_ff)};
        end

        // Shift engine
        unique case (s_ff.st)
            usspi_pkg::USSPI_IDLE: begin
                nxt_s.sclk = c.clock_polarity_select;
                nxt_s.dcnt = '0;
                nxt_s.bcnt = '0;
                if (en && c.master && f_out_valid) begin
                    pop = 1'b1;
                    nxt_s.tx_sh = f_out_data;
                    nxt_s.st = usspi_pkg::USSPI_SHIFT;
                end else if (en && !c.master && sel) begin
                    // A slave with nothing queued answers with zeros
                    pop = f_out_valid;
                    nxt_s.tx_sh = f_out_valid ? f_out_data : usspi_pkg::RST_BYTE;
                    nxt_s.st = usspi_pkg::USSPI_SHIFT;
                end
            end
            usspi_pkg::USSPI_SHIFT: begin
                if (c.master) begin
                    lead = (s_ff.dcnt == '0);
                    trail = (s_ff.dcnt == half);
                    nxt_s.dcnt = (s_ff.dcnt == divc - 16'h0001) ? '0 : s_ff.dcnt + 16'h0001;
                end else if (c.clock_polarity_select) begin
                    lead = s_ff.sck_s[2] && !s_ff.sck_s[1];
                    trail = !s_ff.sck_s[2] && s_ff.sck_s[1];
                end else begin
                    lead = !s_ff.sck_s[2] && s_ff.sck_s[1];
                    trail = s_ff.sck_s[2] && !s_ff.sck_s[1];
                end
                if (lead) begin
                    nxt_s.sclk = !c.clock_polarity_select;
                    nxt_s.dout = s_ff.tx_sh[7];
                    nxt_s.tx_sh = {s_ff.tx_sh[6:0], 1'b0};
                end
                if (trail) begin
                    nxt_s.sclk = c.clock_polarity_select;
                    nxt_s.rx_sh = rx_char;
                    nxt_s.bcnt = s_ff.bcnt + 4'h1;
                    if (s_ff.bcnt == nbits - 4'h1) begin
                        done = 1'b1;
                        nxt_s.st = usspi_pkg::USSPI_IDLE;
                    end
                end
                // Disable or slave deselect abandons a partial character
                if (!en || (!c.master && !sel)) begin
                    nxt_s.st = usspi_pkg::USSPI_IDLE;
                end
            end
            default: nxt_s.st = usspi_pkg::USSPI_IDLE;
        endcase

        // Software writes first, so hardware events below win over them
        if (wr) begin
            unique case (paddr)
                usspi_pkg::A_RCTL: nxt_s.rctl = pwdata[7:0];
                usspi_pkg::A_CTL: nxt_s.ctl = pwdata[7:0];
                usspi_pkg::A_DIVLO: nxt_s.div_lo = pwdata[7:0];
                usspi_pkg::A_DIVHI: nxt_s.div_hi = pwdata[7:0];
                usspi_pkg::A_MOD: nxt_s.modul = pwdata[7:0];
                usspi_pkg::A_TXBUF: begin
                    nxt_s.txlast = pwdata[7:0];
                    nxt_s.tx_flag = 1'b0;
                end
                usspi_pkg::A_ME2: nxt_s.me2 = pwdata[7:0];
                usspi_pkg::A_IE1: nxt_s.ie1 = pwdata[7:0];
                usspi_pkg::A_IE2: nxt_s.ie2 = pwdata[7:0];
                usspi_pkg::A_FLAGS: begin
                    nxt_s.rx_flag = pwdata[usspi_pkg::B_FLG_RX];
                    nxt_s.tx_flag = pwdata[usspi_pkg::B_FLG_TX];
                end
                default: ;
            endcase
        end
        if (rd && (paddr == usspi_pkg::A_RXBUF)) begin
            nxt_s.rctl[usspi_pkg::B_OVERRUN] = 1'b0;
            nxt_s.rx_flag = 1'b0;
        end

        // Hardware-set flags
        if (done) begin
            nxt_s.rxbuf = c.seven_bit ? {1'b0, rx_char[6:0]} : rx_char;
            nxt_s.rx_flag = 1'b1;
            if (s_ff.rx_flag && !(rd && (paddr == usspi_pkg::A_RXBUF))) begin
                nxt_s.rctl[usspi_pkg::B_OVERRUN] = 1'b1;
            end
        end
        if (en && c.master && !c.pin_mode_select && s_ff.ss_s[2] && !s_ff.ss_s[1]) begin
            nxt_s.rctl[usspi_pkg::B_CONFLICT] = 1'b1;
        end
        if (!f_out_valid && !(wr && (paddr == usspi_pkg::A_TXBUF))) begin
            nxt_s.tx_flag = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
            s_ff.tx_flag <= usspi_pkg::RST_FLAGS[usspi_pkg::B_FLG_TX];
            s_ff.st <= usspi_pkg::USSPI_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------------------------------
    // Pins and interrupt requests
    // ----------------------------------------------------------------
    // Master drives clock and data out; slave drives only when selected
    assign serial_clock_pin_o = s_ff.sclk;
    assign serial_clock_pin_oe = en && c.master;
    assign simo_o = s_ff.dout;
    assign simo_oe = en && c.master;
    assign somi_o = s_ff.dout;
    assign somi_oe = en && !c.master && sel;

    generate
        if (CHANNEL == 0) begin : g_ch0
            assign tx_irq = s_ff.tx_flag && s_ff.ie1[usspi_pkg::B_TXIE0];
            assign rx_irq = s_ff.rx_flag && s_ff.ie1[usspi_pkg::B_RXIE0];
        end else begin : g_ch1
            assign tx_irq = s_ff.tx_flag && s_ff.ie2[usspi_pkg::B_TXIE1];
            assign rx_irq = s_ff.rx_flag && s_ff.ie2[usspi_pkg::B_RXIE1];
        end
    endgenerate
endmodule : usspi_top

//--- verification/usspi_monitor.sv
// Port-level checker for the USART SPI-mode channel
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module usspi_monitor #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe,
    input wire logic simo_o,
    input wire logic simo_oe,
    input wire logic somi_oe,
    input wire logic tx_irq,
    input wire logic rx_irq
);
    logic acc;
    logic mapped;
    logic done;

    // Access phase, accepted transfer and address decode
    assign acc = psel && penable;
    assign done = acc && pready;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= usspi_pkg::A_FLAGS);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_answer: assert property (
        acc && !(pwrite && paddr == usspi_pkg::A_TXBUF) |-> pready)
        else $error("register access stalled");
    a_bad_addr: assert property (
        acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    a_good_addr: assert property (
        acc && mapped |-> !pslverr)
        else $error("mapped access refused");
    a_read_pad: assert property (
        acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read lanes not zero");
    a_read_clear: assert property (
        done && !pwrite && paddr == usspi_pkg::A_RXBUF |=> !rx_irq)
        else $error("receive flag kept after buffer read");
    a_tx_clear: assert property (
        done && pwrite && paddr == usspi_pkg::A_TXBUF |=> !tx_irq)
        else $error("transmit flag kept after buffer write");
    a_simo_edge: assert property (
        $changed(simo_o) && simo_oe && $past(simo_oe) |-> $changed(serial_clock_pin_o))
        else $error("data changed away from a clock edge");
    a_drive_pair: assert property (
        serial_clock_pin_oe == simo_oe)
        else $error("clock and data drivers disagree");
    a_slave_quiet: assert property (
        serial_clock_pin_oe |-> !somi_oe)
        else $error("slave output driven in master mode");

    // Main scenarios reached
    c_stall: cover property (acc && !pready);
    c_rx: cover property ($rose(rx_irq));
    c_err: cover property (acc && pslverr);
endmodule : usspi_monitor

bind usspi_top usspi_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) usspi_monitor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe(serial_clock_pin_oe),
    .simo_o(simo_o), .simo_oe(simo_oe), .somi_oe(somi_oe), .tx_irq(tx_irq), .rx_irq(rx_irq)
);

//--- verification/usspi_partner.sv
// Behavioural SPI slave answering the channel while it is master
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Partner slave
// ----------------------------------------------------------------
module usspi_partner (
    input wire logic sclk,
    input wire logic active,
    input wire logic mosi,
    input wire logic [3:0] bits,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got,
    output int frames
);
    logic [7:0] sr;
    logic [3:0] cnt;

    // One process owns every output, so each has a single driver
    initial begin
        miso = 1'b0;
        cnt = 4'h0;
        got = 8'h00;
        frames = 0;
        forever begin
            // Leading (rising) edge: next reply bit out, MSB first
            @(posedge sclk);
            if (active) begin
                if (cnt == 4'h0) begin
                    sr = reply;
                end
                miso <= sr[7];
                sr = {sr[6:0], 1'b0};
            end
            // Trailing edge: sample; after the frame the released line must not hold its value
            @(negedge sclk);
            if (active) begin
                got = {got[6:0], mosi};
                cnt = cnt + 4'h1;
                if (cnt == bits) begin
                    cnt = 4'h0;
                    frames++;
                    #40 miso = ~miso;
                end
            end
        end
    end
endmodule : usspi_partner

//--- verification/usart_spi_mode_registers_bench.sv
// Self-checking bench for the USART SPI-mode channel
`timescale 1ns/1ns

module usart_spi_mode_registers_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, reply, got;
    logic [31:0] pwdata, prdata, rd;
    logic sclk, sclk_oe, simo, simo_oe, somi, sel_n, tx_irq, rx_irq;
    logic [3:0] bits;
    logic ext_sck, ext_mosi, somi_out, somi_en;
    logic [7:0] shifted;
    int frames, failures, check_count, waits;

    // ----------------------------------------------------------------
    // Clock, design and partner
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    usspi_top #(.CHANNEL(1), .FIFO_DEPTH(32)) usspi_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_clock_pin_i(ext_sck), .serial_clock_pin_o(sclk), .serial_clock_pin_oe(sclk_oe),
        .simo_i(ext_mosi), .simo_o(simo), .simo_oe(simo_oe), .somi_i(somi), .somi_o(somi_out),
        .somi_oe(somi_en), .slave_select_pin_i(sel_n), .tx_irq(tx_irq), .rx_irq(rx_irq)
    );

    usspi_partner usspi_partner_inst (
        .sclk(sclk), .active(sclk_oe), .mosi(simo), .bits(bits), .reply(reply),
        .miso(somi), .got(got), .frames(frames)
    );

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // One APB transfer; only the watchdog may end a wait on pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        waits = 0;
        do begin
            @(posedge pclk);
            waits++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [7:0] want);
        apb(1'b0, a, 8'h00);
        check(rd, {24'h00_0000, want});
    endtask : rdchk

    // Wait until the partner has seen k frames, then let the flags land
    task automatic await(input int k);
        while (frames < k) begin
            @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
    endtask : await

    task automatic conclude();
        $display("checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    // Watchdog: whole run needs about 5000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        sel_n = 1'b1;
        ext_sck = 1'b0;
        ext_mosi = 1'b0;
        bits = 4'h8;
        reply = 8'h3C;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(usspi_pkg::A_RCTL, 8'h00);
        rdchk(usspi_pkg::A_ME2, 8'h00);
        rdchk(usspi_pkg::A_IE1, 8'h00);
        rdchk(usspi_pkg::A_IE2, 8'h00);
        rdchk(usspi_pkg::A_FLAGS, usspi_pkg::RST_FLAGS);
        check({31'h0, tx_irq}, 32'h0);
        apb(1'b1, usspi_pkg::A_RCTL, 8'hFF);
        rdchk(usspi_pkg::A_RCTL, 8'hFF);
        apb(1'b1, usspi_pkg::A_RCTL, 8'h00);
        apb(1'b0, 8'h2C, 8'h00);
        check({err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, usspi_pkg::A_IE1, 8'hC0);
        rdchk(usspi_pkg::A_IE1, 8'hC0);
        apb(1'b1, usspi_pkg::A_IE2, 8'h20);
        // The write lands at the sampling edge; look one edge later
        @(posedge pclk);
        check({31'h0, tx_irq}, 32'h1);
        apb(1'b1, usspi_pkg::A_IE2, 8'h30);
        // Master, 4-pin, polarity 0, divider 16 keeps bits clear of the input synchronisers
        apb(1'b1, usspi_pkg::A_CTL, 8'h01);
        apb(1'b1, usspi_pkg::A_DIVLO, 8'h10);
        apb(1'b1, usspi_pkg::A_DIVHI, 8'h00);
        apb(1'b1, usspi_pkg::A_MOD, 8'h00);
        apb(1'b1, usspi_pkg::A_TXBUF, 8'hA5);
        rdchk(usspi_pkg::A_FLAGS, 8'h00);
        apb(1'b1, usspi_pkg::A_ME2, 8'h10);
        await(1);
        check({24'h0, got}, 32'h0000_00A5);
        check({31'h0, rx_irq}, 32'h1);
        rdchk(usspi_pkg::A_RXBUF, 8'h3C);
        @(posedge pclk);
        check({31'h0, rx_irq}, 32'h0);
        // Two characters without reading in between
        apb(1'b1, usspi_pkg::A_TXBUF, 8'h11);
        apb(1'b1, usspi_pkg::A_TXBUF, 8'h22);
        await(3);
        rdchk(usspi_pkg::A_RCTL, 8'h20);
        rdchk(usspi_pkg::A_RXBUF, 8'h3C);
        rdchk(usspi_pkg::A_RCTL, 8'h00);
        // Seven-bit character, data MSB-justified by software
        apb(1'b1, usspi_pkg::A_CTL, 8'h09);
        bits = 4'h7;
        reply = 8'hB6;
        apb(1'b1, usspi_pkg::A_TXBUF, 8'hA4);
        await(4);
        check({25'h0, got[6:0]}, 32'h0000_0052);
        rdchk(usspi_pkg::A_RXBUF, 8'h5B);
        // Fill the buffer until it stalls a write, then drain it
        apb(1'b1, usspi_pkg::A_CTL, 8'h01);
        bits = 4'h8;
        for (int i = 0; i < 33; i++) begin
            apb(1'b1, usspi_pkg::A_TXBUF, 8'(i));
        end
        apb(1'b1, usspi_pkg::A_TXBUF, 8'hEE);
        check({31'h0, waits > 5}, 32'h1);
        await(38);
        check({24'h0, got}, 32'h0000_00EE);
        check({31'h0, tx_irq}, 32'h1);
        apb(1'b0, usspi_pkg::A_RXBUF, 8'h00);
        // Slave-select falls: ignored in 3-pin, conflict in 4-pin master
        apb(1'b1, usspi_pkg::A_CTL, 8'h05);
        sel_n <= 1'b0;
        repeat (6) @(posedge pclk);
        rdchk(usspi_pkg::A_RCTL, 8'h00);
        sel_n <= 1'b1;
        apb(1'b1, usspi_pkg::A_CTL, 8'h01);
        repeat (6) @(posedge pclk);
        sel_n <= 1'b0;
        repeat (6) @(posedge pclk);
        rdchk(usspi_pkg::A_RCTL, 8'h80);
        sel_n <= 1'b1;
        apb(1'b1, usspi_pkg::A_CTL, 8'h03);
        repeat (3) @(posedge pclk);
        check({31'h0, sclk}, 32'h1);
        // Slave, 4-pin, polarity 0: the bench plays master on the pins
        apb(1'b1, usspi_pkg::A_CTL, 8'h00);
        apb(1'b1, usspi_pkg::A_TXBUF, 8'hC3);
        sel_n <= 1'b0;
        repeat (6) @(posedge pclk);
        check({31'h0, somi_en}, 32'h1);
        // Five cycles per half bit leave room for the three-stage pin synchronisers
        for (int i = 7; i >= 0; i--) begin
            ext_sck <= 1'b1;
            ext_mosi <= i[0];
            repeat (5) @(posedge pclk);
            shifted[i] = somi_out;
            ext_sck <= 1'b0;
            repeat (5) @(posedge pclk);
        end
        check({24'h0, shifted}, 32'h0000_00C3);
        rdchk(usspi_pkg::A_RXBUF, 8'hAA);
        sel_n <= 1'b1;
        conclude();
    end
endmodule : usart_spi_mode_registers_bench
